// ===== core/pps_pkg.sv
// constants and types shared by the predefined protocol sequencer
package pps_pkg;

  // ----------------------------------------------------------------
  // clock and timer base
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int TIMER_UNIT_MS = 500;
  localparam int UNIT_CYCLES = TIMER_UNIT_MS * (CLK_HZ / 1000);
  localparam int TICK_W = 24;
  localparam int TMR_W = 16;
  localparam int ALIVE_W = 20;

  // ----------------------------------------------------------------
  // packet storage
  // ----------------------------------------------------------------
  localparam int MAX_PKTS = 16;
  localparam int PKT_BYTES = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 9;
  localparam logic [4:0] MAX_PKTS_5 = 5'h10;
  localparam logic [3:0] PKT_BYTES_4 = 4'h8;
  localparam logic [4:0] MATCH_NONE = 5'h00;

  // ----------------------------------------------------------------
  // failure codes
  // ----------------------------------------------------------------
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_SEND_TIMEOUT = 16'h0001;
  localparam logic [15:0] ERR_RECV_TIMEOUT = 16'h0002;
  localparam logic [15:0] ERR_ALIVE = 16'h0003;
  localparam logic [15:0] ERR_BAD_TYPE = 16'h0004;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PPS_TYPE_NONE = 2'h0,
    PPS_TYPE_SEND = 2'h1,
    PPS_TYPE_RECV = 2'h2,
    PPS_TYPE_SENDRECV = 2'h3
  } pps_type_e;

  typedef enum logic [2:0] {
    PPS_S_IDLE = 3'h0,
    PPS_S_SEND = 3'h1,
    PPS_S_SEND_WAIT = 3'h2,
    PPS_S_RECV = 3'h3
  } pps_state_e;

  typedef enum logic [1:0] {
    PPS_C_CLOSED = 2'h0,
    PPS_C_OPENING = 2'h1,
    PPS_C_OPEN = 2'h2
  } pps_conn_e;

endpackage

// ===== core/pps_sequencer.sv
// predefined protocol sequencer with its receive fifo
// What this block does
// - send-only transmits the selected packet exactly once and then finishes.
// - receive-only finishes normally only when incoming data equal a registered expected packet.
// - frames that match no registered packet are dropped and the wait goes on.
// - bytes marked variable in an expected packet are accepted without checking.
// - at most sixteen expected packets take part in one receive.
// - packets are compared in registration order and the first match ends it.
// - the matched packet number goes to the control data and to the buffer location.
// - send-then-receive enters the receive wait only after a normal send finish.
// - no match before the receive wait time runs out ends the instruction abnormally.
// - no sign of the peer within the alive-check time ends the instruction abnormally.
// - a send timeout in send-then-receive ends abnormally instead of waiting to receive.
// - every abnormal end leaves a failure code for the controller to read.
// - a started passive open cannot be withdrawn; close is honoured only once open.
`timescale 1ns/10ps

module pps_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  assign next_count = count + CW'(push) - CW'(pop);
  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= next_count;
      in_ready_o <= next_count != CW'(DEPTH);
      out_valid_o <= next_count != '0;
    end
  end
endmodule // pps_fifo

module pps_sequencer #(
  parameter int UNIT_CYCLES = pps_pkg::UNIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [1:0] comm_type_i,
  input wire logic [3:0] tx_len_i,
  input wire logic [15:0] wait_time_i,
  input wire logic [15:0] alive_start_i,
  input wire logic [15:0] alive_interval_i,
  input wire logic [3:0] alive_retry_i,
  input wire logic [4:0] exp_count_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_tx_i,
  input wire logic [3:0] cfg_sel_i,
  input wire logic [2:0] cfg_pos_i,
  input wire logic [7:0] cfg_byte_i,
  input wire logic cfg_var_i,
  input wire logic exp_len_wr_i,
  input wire logic [3:0] exp_len_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic tx_sent_i,
  input wire logic tx_timeout_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_last_i,
  output logic rx_ready_o,
  input wire logic peer_alive_i,
  input wire logic open_req_i,
  input wire logic close_req_i,
  input wire logic peer_conn_i,
  output logic open_busy_o,
  output logic conn_open_o,
  output logic busy_o,
  output logic done_o,
  output logic fail_o,
  output logic [15:0] err_code_o,
  output logic [4:0] ctl_match_o,
  output logic [4:0] buf_match_o
);
  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [7:0] tx_mem [pps_pkg::PKT_BYTES];
  logic [7:0] exp_mem [pps_pkg::MAX_PKTS][pps_pkg::PKT_BYTES];
  logic [7:0] exp_var [pps_pkg::MAX_PKTS];
  logic [3:0] exp_len [pps_pkg::MAX_PKTS];
  pps_pkg::pps_state_e state, next_state;
  pps_pkg::pps_type_e typ;
  pps_pkg::pps_conn_e conn, next_conn;
  logic [3:0] tx_len_q;
  logic [2:0] tx_idx;
  logic [4:0] cnt_q;
  logic [3:0] pos;
  logic [15:0] live;
  logic [15:0] byte_ok;
  logic [15:0] frame_hit;
  logic [pps_pkg::TICK_W-1:0] presc;
  logic [pps_pkg::TMR_W-1:0] wait_cnt, wait_limit;
  logic [pps_pkg::ALIVE_W-1:0] alive_cnt, alive_limit;
  logic fin_ok, fin_fail;
  logic [15:0] next_err;
  logic f_valid, f_last;
  logic [7:0] f_data;

  function automatic logic [4:0] first_hit(input logic [15:0] m);
    logic [4:0] r;
    r = pps_pkg::MATCH_NONE;
    for (int k = pps_pkg::MAX_PKTS - 1; k >= 0; k--) begin
      if (m[k]) begin
        r = 5'(k + 1);
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // receive fifo
  // ----------------------------------------------------------------
  wire rx_pop = f_valid & (state == pps_pkg::PPS_S_RECV);
  wire frame_end = rx_pop & f_last;

  pps_fifo #(
    .WIDTH(pps_pkg::FIFO_WIDTH),
    .DEPTH(pps_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(rx_valid_i),
    .in_data_i({rx_last_i, rx_data_i}),
    .in_ready_o(rx_ready_o),
    .out_valid_o(f_valid),
    .out_data_o({f_last, f_data}),
    .out_ready_i(rx_pop)
  );

  // ----------------------------------------------------------------
  // matcher
  // ----------------------------------------------------------------
  generate
    for (genvar k = 0; k < pps_pkg::MAX_PKTS; k++) begin : g_cmp
      assign byte_ok[k] = (pos < exp_len[k]) &&
        (exp_var[k][pos[2:0]] || exp_mem[k][pos[2:0]] == f_data);
      assign frame_hit[k] = live[k] & byte_ok[k] &&
        (pos + 4'h1 == exp_len[k]) && (5'(k) < cnt_q);
    end
  endgenerate

  wire [4:0] hit_num = first_hit(frame_hit);
  wire matched = frame_end && hit_num != pps_pkg::MATCH_NONE;
  wire tick = presc == pps_pkg::TICK_W'(UNIT_CYCLES - 1);
  wire wait_exp = wait_limit != '0 && wait_cnt >= wait_limit;
  wire alive_exp = alive_limit != '0 && alive_cnt >= alive_limit;
  wire tx_fire = tx_valid_o & tx_ready_i;
  wire start_ok = state == pps_pkg::PPS_S_IDLE && start_i;
  wire enter_send = start_ok && next_state == pps_pkg::PPS_S_SEND;

  // ----------------------------------------------------------------
  // sequence control
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    fin_ok = 1'b0;
    fin_fail = 1'b0;
    next_err = pps_pkg::ERR_NONE;
    case (state)
      pps_pkg::PPS_S_IDLE: begin
        if (start_i) begin
          case (comm_type_i)
            pps_pkg::PPS_TYPE_SEND, pps_pkg::PPS_TYPE_SENDRECV: begin
              next_state = pps_pkg::PPS_S_SEND;
            end
            pps_pkg::PPS_TYPE_RECV: begin
              next_state = pps_pkg::PPS_S_RECV;
            end
            default: begin
              fin_fail = 1'b1;
              next_err = pps_pkg::ERR_BAD_TYPE;
            end
          endcase
        end
      end
      pps_pkg::PPS_S_SEND, pps_pkg::PPS_S_SEND_WAIT: begin
        if (tx_timeout_i) begin
          fin_fail = 1'b1;
          next_err = pps_pkg::ERR_SEND_TIMEOUT;
        end else if (alive_exp) begin
          fin_fail = 1'b1;
          next_err = pps_pkg::ERR_ALIVE;
        end else if (state == pps_pkg::PPS_S_SEND) begin
          if (tx_fire && tx_last_o) begin
            next_state = pps_pkg::PPS_S_SEND_WAIT;
          end
        end else if (tx_sent_i) begin
          if (typ == pps_pkg::PPS_TYPE_SEND) begin
            fin_ok = 1'b1;
          end else begin
            next_state = pps_pkg::PPS_S_RECV;
          end
        end
      end
      pps_pkg::PPS_S_RECV: begin
        if (matched) begin
          fin_ok = 1'b1;
        end else if (wait_exp) begin
          fin_fail = 1'b1;
          next_err = pps_pkg::ERR_RECV_TIMEOUT;
        end else if (alive_exp) begin
          fin_fail = 1'b1;
          next_err = pps_pkg::ERR_ALIVE;
        end
      end
      default: begin
        next_state = pps_pkg::PPS_S_IDLE;
      end
    endcase
    if (fin_ok || fin_fail) begin
      next_state = pps_pkg::PPS_S_IDLE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= pps_pkg::PPS_S_IDLE;
      typ <= pps_pkg::PPS_TYPE_NONE;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      fail_o <= 1'b0;
      err_code_o <= pps_pkg::ERR_NONE;
    end else begin
      state <= next_state;
      busy_o <= next_state != pps_pkg::PPS_S_IDLE;
      done_o <= fin_ok | fin_fail;
      if (start_ok) begin
        typ <= pps_pkg::pps_type_e'(comm_type_i);
      end
      if (fin_fail) begin
        fail_o <= 1'b1;
        err_code_o <= next_err;
      end else if (start_ok) begin
        fail_o <= 1'b0;
        err_code_o <= pps_pkg::ERR_NONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // settings latched at start
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
      tx_len_q <= '0;
      wait_limit <= '0;
      alive_limit <= '0;
    end else if (start_ok) begin
      cnt_q <= exp_count_i > pps_pkg::MAX_PKTS_5 ? pps_pkg::MAX_PKTS_5 : exp_count_i;
      tx_len_q <= tx_len_i > pps_pkg::PKT_BYTES_4 ? pps_pkg::PKT_BYTES_4 : tx_len_i;
      wait_limit <= wait_time_i;
      alive_limit <= 20'(alive_start_i) + 20'(alive_interval_i) * 20'(alive_retry_i);
    end
  end

  // ----------------------------------------------------------------
  // packet memories
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (cfg_wr_i && cfg_tx_i) begin
      tx_mem[cfg_pos_i] <= cfg_byte_i;
    end
    if (cfg_wr_i && !cfg_tx_i) begin
      exp_mem[cfg_sel_i][cfg_pos_i] <= cfg_byte_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      exp_var <= '{default: '0};
      exp_len <= '{default: '0};
    end else begin
      if (cfg_wr_i && !cfg_tx_i) begin
        exp_var[cfg_sel_i][cfg_pos_i] <= cfg_var_i;
      end
      if (exp_len_wr_i) begin
        exp_len[cfg_sel_i] <= exp_len_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit
  // ----------------------------------------------------------------
  wire [2:0] tx_sel = enter_send ? 3'h0 : tx_idx;
  wire [3:0] tx_end = enter_send ? (tx_len_i == 4'h0 ? 4'h1 : tx_len_i) : tx_len_q;
  wire tx_load = enter_send || (tx_fire && !tx_last_o && state == pps_pkg::PPS_S_SEND);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= '0;
      tx_last_o <= 1'b0;
      tx_idx <= '0;
    end else if (tx_load) begin
      tx_valid_o <= 1'b1;
      tx_data_o <= tx_mem[tx_sel];
      tx_last_o <= {1'b0, tx_sel} + 4'h1 >= tx_end;
      tx_idx <= tx_sel + 3'h1;
    end else if (next_state != pps_pkg::PPS_S_SEND || tx_fire) begin
      tx_valid_o <= 1'b0;
      tx_last_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // frame tracking and match report
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pos <= '0;
      live <= '1;
      ctl_match_o <= pps_pkg::MATCH_NONE;
      buf_match_o <= pps_pkg::MATCH_NONE;
    end else begin
      if (frame_end || state == pps_pkg::PPS_S_IDLE) begin
        pos <= '0;
        live <= '1;
      end else if (rx_pop) begin
        pos <= pos == pps_pkg::PKT_BYTES_4 ? pos : pos + 4'h1;
        live <= live & byte_ok;
      end
      if (start_ok) begin
        ctl_match_o <= pps_pkg::MATCH_NONE;
      end else if (matched && state == pps_pkg::PPS_S_RECV) begin
        ctl_match_o <= hit_num;
        buf_match_o <= hit_num;
      end
    end
  end

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      presc <= '0;
      wait_cnt <= '0;
      alive_cnt <= '0;
    end else begin
      presc <= (state == pps_pkg::PPS_S_IDLE || tick) ? '0 : presc + 1'b1;
      if (state != pps_pkg::PPS_S_RECV) begin
        wait_cnt <= '0;
      end else if (tick && !wait_exp) begin
        wait_cnt <= wait_cnt + 1'b1;
      end
      if (state == pps_pkg::PPS_S_IDLE || peer_alive_i) begin
        alive_cnt <= '0;
      end else if (tick && !alive_exp) begin
        alive_cnt <= alive_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // passive open
  // ----------------------------------------------------------------
  always_comb begin
    next_conn = conn;
    case (conn)
      pps_pkg::PPS_C_CLOSED: begin
        if (open_req_i) begin
          next_conn = pps_pkg::PPS_C_OPENING;
        end
      end
      pps_pkg::PPS_C_OPENING: begin
        if (peer_conn_i) begin
          next_conn = pps_pkg::PPS_C_OPEN;
        end
      end
      pps_pkg::PPS_C_OPEN: begin
        if (close_req_i) begin
          next_conn = pps_pkg::PPS_C_CLOSED;
        end
      end
      default: begin
        next_conn = pps_pkg::PPS_C_CLOSED;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conn <= pps_pkg::PPS_C_CLOSED;
      open_busy_o <= 1'b0;
      conn_open_o <= 1'b0;
    end else begin
      conn <= next_conn;
      open_busy_o <= next_conn == pps_pkg::PPS_C_OPENING;
      conn_open_o <= next_conn == pps_pkg::PPS_C_OPEN;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_send_once;
    @(posedge clk_i) disable iff (!rst_b_i)
      (tx_fire && tx_last_o) |=> !tx_valid_o [*2];
  endproperty
  a_send_once: assert property (p_send_once) else $error("second send");

  property p_recv_match;
    @(posedge clk_i) disable iff (!rst_b_i)
      (done_o && !fail_o && typ != pps_pkg::PPS_TYPE_SEND) |-> $past(frame_end);
  endproperty
  a_recv_match: assert property (p_recv_match) else $error("recv end without frame");

  property p_discard;
    @(posedge clk_i) disable iff (!rst_b_i)
      (frame_end && !matched && !wait_exp && !alive_exp) |=>
        state == pps_pkg::PPS_S_RECV && !done_o && pos == 4'h0;
  endproperty
  a_discard: assert property (p_discard) else $error("unmatched frame ended wait");

  property p_var_skip;
    @(posedge clk_i) disable iff (!rst_b_i)
      (pos < exp_len[0] && exp_var[0][pos[2:0]]) |-> byte_ok[0];
  endproperty
  a_var_skip: assert property (p_var_skip) else $error("variable byte checked");

  property p_max_pkts;
    @(posedge clk_i) disable iff (!rst_b_i)
      cnt_q <= pps_pkg::MAX_PKTS_5 && !(frame_hit[15:0] != '0 && hit_num == 5'h00);
  endproperty
  a_max_pkts: assert property (p_max_pkts) else $error("packet count over limit");

  property p_first;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rx_pop && f_last && frame_hit[0]) |=> ctl_match_o == 5'h01 && done_o;
  endproperty
  a_first: assert property (p_first) else $error("first registered not chosen");

  property p_report;
    @(posedge clk_i) disable iff (!rst_b_i)
      (done_o && !fail_o && typ != pps_pkg::PPS_TYPE_SEND) |->
        ctl_match_o == buf_match_o && ctl_match_o != pps_pkg::MATCH_NONE;
  endproperty
  a_report: assert property (p_report) else $error("match number not stored");

  property p_recv_after_send;
    @(posedge clk_i) disable iff (!rst_b_i)
      (state == pps_pkg::PPS_S_RECV && $past(state) == pps_pkg::PPS_S_SEND_WAIT) |->
        $past(tx_sent_i);
  endproperty
  a_recv_after_send: assert property (p_recv_after_send) else $error("recv before send");

  property p_wait_to;
    @(posedge clk_i) disable iff (!rst_b_i)
      (state == pps_pkg::PPS_S_RECV && wait_exp && !matched) |=>
        done_o && fail_o && err_code_o == pps_pkg::ERR_RECV_TIMEOUT;
  endproperty
  a_wait_to: assert property (p_wait_to) else $error("receive timeout missed");

  property p_alive_to;
    @(posedge clk_i) disable iff (!rst_b_i)
      (state != pps_pkg::PPS_S_IDLE && alive_exp && !matched && !wait_exp && !tx_timeout_i)
        |=> fail_o && err_code_o == pps_pkg::ERR_ALIVE;
  endproperty
  a_alive_to: assert property (p_alive_to) else $error("alive timeout missed");

  property p_send_to;
    @(posedge clk_i) disable iff (!rst_b_i)
      (state inside {pps_pkg::PPS_S_SEND, pps_pkg::PPS_S_SEND_WAIT} && tx_timeout_i) |=>
        state == pps_pkg::PPS_S_IDLE && err_code_o == pps_pkg::ERR_SEND_TIMEOUT;
  endproperty
  a_send_to: assert property (p_send_to) else $error("send timeout missed");

  property p_open_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
      (conn == pps_pkg::PPS_C_OPENING && !peer_conn_i) |=> open_busy_o;
  endproperty
  a_open_hold: assert property (p_open_hold) else $error("open withdrawn");

  property p_wait_tmr;
    @(posedge clk_i) disable iff (!rst_b_i)
      (state != pps_pkg::PPS_S_RECV) |=> wait_cnt == '0;
  endproperty
  a_wait_tmr: assert property (p_wait_tmr) else $error("wait timer ran outside wait");

  property p_done;
    @(posedge clk_i) disable iff (!rst_b_i)
      done_o |-> !busy_o ##1 (!done_o || $past(start_i));
  endproperty
  a_done: assert property (p_done) else $error("done while busy");

  c_send_ok: cover property (@(posedge clk_i) done_o && !fail_o && typ == pps_pkg::PPS_TYPE_SEND);
  c_recv_ok: cover property (@(posedge clk_i) done_o && !fail_o && ctl_match_o > 5'h01);
  c_wait_to: cover property (@(posedge clk_i) done_o && err_code_o == pps_pkg::ERR_RECV_TIMEOUT);
  c_discard: cover property (@(posedge clk_i) frame_end && !matched);
endmodule // pps_sequencer

// ===== tb/pps_peer.sv
// link partner model that takes the sequencer's send stream
`timescale 1ns/10ps
module pps_peer (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic tx_valid_i,
  input wire logic tx_last_i,
  input wire logic to_i,
  output logic tx_ready_o,
  output logic tx_sent_o,
  output logic tx_timeout_o,
  output int nbytes_o
);
  // ------------------------------------------
  // random stalls, byte count, send outcome
  // ------------------------------------------
  wire logic take = tx_valid_i && tx_ready_o;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_ready_o <= 1'h0;
      tx_sent_o <= 1'h0;
      tx_timeout_o <= 1'h0;
      nbytes_o <= 0;
    end else begin
      tx_ready_o <= 1'($urandom_range(1));
      tx_sent_o <= take && tx_last_i && !to_i;
      tx_timeout_o <= take && tx_last_i && to_i;
      if (take) nbytes_o <= nbytes_o + 1;
    end
  end
endmodule // pps_peer

// ===== tb/tb.sv
// self-checking bench for the predefined protocol sequencer
`timescale 1ns/10ps
module tb;
  // ------------------------------------------
  // signals, design and partner
  // ------------------------------------------
  logic clk_i = 0, rst_b_i = 0, start_i = 0, cfg_wr_i = 0, cfg_tx_i = 0, cfg_var_i = 0;
  logic exp_len_wr_i = 0, rx_valid_i = 0, rx_last_i = 0, open_req_i = 0, close_req_i = 0;
  logic peer_conn_i = 0, to = 0, ok, peer_alive_i = 0;
  logic [1:0] comm_type_i = 0;
  logic [3:0] tx_len_i = 4'h2, cfg_sel_i = 0, exp_len_i = 4'h4, alive_retry_i = 0;
  logic [2:0] cfg_pos_i = 0;
  logic [7:0] cfg_byte_i = 0, rx_data_i = 0, eb[3][4], f[4], txb[2];
  logic [15:0] wait_time_i = 16'h000a, alive_start_i = 0, alive_interval_i = 0;
  logic [4:0] exp_count_i = 5'h03, m, ctl_match_o, buf_match_o;
  logic tx_valid_o, tx_last_o, tx_ready_i, tx_sent_i, tx_timeout_i, rx_ready_o;
  logic open_busy_o, conn_open_o, busy_o, done_o, fail_o, ev[3][4];
  logic [7:0] tx_data_o;
  logic [15:0] err_code_o;
  int err_total = 0, checks = 0, nb, n0, ti = 0;
  pps_sequencer #(.UNIT_CYCLES(4)) dut (.clk_i, .rst_b_i, .start_i, .comm_type_i, .tx_len_i,
    .wait_time_i, .alive_start_i, .alive_interval_i, .alive_retry_i,
    .exp_count_i, .cfg_wr_i, .cfg_tx_i, .cfg_sel_i, .cfg_pos_i, .cfg_byte_i, .cfg_var_i,
    .exp_len_wr_i, .exp_len_i, .tx_valid_o, .tx_data_o, .tx_last_o, .tx_ready_i, .tx_sent_i,
    .tx_timeout_i, .rx_valid_i, .rx_data_i, .rx_last_i, .rx_ready_o, .peer_alive_i,
    .open_req_i, .close_req_i, .peer_conn_i, .open_busy_o, .conn_open_o, .busy_o, .done_o,
    .fail_o, .err_code_o, .ctl_match_o, .buf_match_o);
  pps_peer peer (.clk_i, .rst_b_i, .tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o), .to_i(to),
    .tx_ready_o(tx_ready_i), .tx_sent_o(tx_sent_i), .tx_timeout_o(tx_timeout_i), .nbytes_o(nb));
  initial forever #20 clk_i = ~clk_i;
  // ------------------------------------------
  // tasks and expectation
  // ------------------------------------------
  task automatic cyc(int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(logic c, string s);
    checks++;
    if (c !== 1'h1) begin
      err_total++;
      $display("ERROR %0t %s", $time, s);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc();
    s = 1'h0;
    cyc();
  endtask
  task automatic run(logic [1:0] t, logic [15:0] e, logic [4:0] x);
    int i;
    comm_type_i = t;
    start_i = 1'h1;
    cyc();
    start_i = 1'h0;
    for (i = 0; i < 300 && done_o !== 1'h1; i++) cyc();
    chk(i < 300, "no end of instruction");
    if (i == 300) wrap_up();
    chk(fail_o === (e != 16'h0000) && err_code_o === e, "end status");
    chk(ctl_match_o === x, "control match number");
    if (x != 5'h00) chk(buf_match_o === x, "buffer match number");
  endtask
  task automatic frame();
    int k, w;
    for (k = 0; k < 4; k++) begin
      rx_valid_i = 1'h1;
      rx_data_i = f[k];
      rx_last_i = (k == 3);
      for (w = 0; rx_ready_o !== 1'h1 && w < 50; w++) cyc();
      chk(w < 50, "receive stream stalled");
      if (w == 50) wrap_up();
      cyc();
    end
    rx_valid_i = 1'h0;
    rx_last_i = 1'h0;
    rx_data_i = ~rx_data_i;
  endtask
  function automatic logic [4:0] want();
    for (int s = 0; s < 3; s++) begin
      ok = 1'h1;
      for (int p = 0; p < 4; p++) if (!ev[s][p] && eb[s][p] !== f[p]) ok = 1'h0;
      if (ok) return 5'(s + 1);
    end
    return 5'h00;
  endfunction
  always @(negedge clk_i) begin
    if (tx_valid_o === 1'h1 && tx_ready_i === 1'h1) begin
      chk(tx_data_o === txb[ti] && tx_last_o === (ti == 1), "send byte");
      ti = tx_last_o ? 0 : ti + 1;
    end
  end
  // ------------------------------------------
  // main sequence
  // ------------------------------------------
  initial begin
    void'($urandom(32'hdc8b));
    cyc(3);
    rst_b_i = 1'h1;
    cyc();
    cfg_wr_i = 1'h1;
    foreach (eb[s, p]) begin
      eb[s][p] = (s == 2) ? eb[1][p] : 8'($urandom);
      ev[s][p] = (s == 1 && p == 2);
      {cfg_sel_i, cfg_pos_i, cfg_byte_i, cfg_var_i} = {4'(s), 3'(p), eb[s][p], ev[s][p]};
      cyc();
    end
    cfg_tx_i = 1'h1;
    foreach (txb[p]) begin
      txb[p] = 8'($urandom);
      {cfg_pos_i, cfg_byte_i} = {3'(p), txb[p]};
      cyc();
    end
    cfg_wr_i = 1'h0;
    for (int s = 0; s < 3; s++) begin
      cfg_sel_i = 4'(s);
      pulse(exp_len_wr_i);
    end
    n0 = nb;
    run(2'h1, pps_pkg::ERR_NONE, 5'h00);
    chk(nb - n0 == 2, "send byte count");
    run(2'h0, pps_pkg::ERR_BAD_TYPE, 5'h00);
    cyc();
    to = 1'h1;
    run(2'h3, pps_pkg::ERR_SEND_TIMEOUT, 5'h00);
    to = 1'h0;
    run(2'h2, pps_pkg::ERR_RECV_TIMEOUT, 5'h00);
    {wait_time_i, alive_start_i, alive_interval_i, alive_retry_i} = {16'h0, 16'h1, 16'h1, 4'h1};
    run(2'h2, pps_pkg::ERR_ALIVE, 5'h00);
    wait_time_i = 16'h000a;
    fork
      run(2'h2, pps_pkg::ERR_RECV_TIMEOUT, 5'h00);
      repeat (30) pulse(peer_alive_i);
    join
    {alive_start_i, alive_interval_i, alive_retry_i} = 36'h0;
    f = eb[0];
    f[0] = ~f[0];
    fork
      run(2'h2, pps_pkg::ERR_NONE, 5'h02);
      begin
        frame();
        cyc(4);
        chk(busy_o === 1'h1, "unmatched frame ended receive");
        f = eb[2];
        f[2] = ~f[2];
        frame();
      end
    join
    foreach (eb[s]) begin
      f = eb[s];
      fork
        run(2'h2, pps_pkg::ERR_NONE, (s == 0) ? 5'h01 : 5'h02);
        frame();
      join
    end
    repeat (8) begin
      f = eb[$urandom_range(2)];
      f[2] = 8'($urandom);
      if ($urandom_range(1)) f[3] = ~f[3];
      m = want();
      fork
        run($urandom_range(1) ? 2'h2 : 2'h3, (m != 0) ? 16'h0000 : 16'h0002, m);
        frame();
      join
    end
    pulse(open_req_i);
    pulse(close_req_i);
    chk(open_busy_o === 1'h1 && conn_open_o === 1'h0, "open withdrawn");
    pulse(peer_conn_i);
    chk(conn_open_o === 1'h1, "open not complete");
    pulse(close_req_i);
    chk(conn_open_o === 1'h0, "close not taken");
    wrap_up();
  end
endmodule // tb
